//--- rtl/drf_pkg.sv
// constants, register map and types of the display refresh fetch block
package drf_pkg;
  // storage geometry
  localparam int Q_DEPTH = 64;
  localparam int Q_WIDTH = 64;
  localparam int CB_DEPTH = 64;
  localparam int CB_WIDTH = 32;
  localparam int CUR_SIZE = 32;
  localparam int PAL_ENTRIES = 256;
  localparam int PAL_EXT = 3;
  localparam int PAL_W = 18;
  localparam int LINE_W = 10;
  localparam int LINES_DEF = 1024;
  localparam int X_W = 11;
  // register offsets
  localparam logic [15:0] OFF_CTRL = 16'h8300;
  localparam logic [15:0] OFF_THRESH = 16'h8304;
  localparam logic [15:0] OFF_STATIC = 16'h8308;
  localparam logic [15:0] OFF_CURPOS = 16'h830C;
  localparam logic [15:0] OFF_STATUS = 16'h8310;
  localparam logic [15:0] OFF_PALADR = 16'h8314;
  localparam logic [15:0] OFF_PALDAT = 16'h8318;
  localparam logic [15:0] OFF_CURCOL = 16'h8360;
  // control and status field positions
  localparam int CTRL_BPP16 = 0;
  localparam int CTRL_PANEL = 1;
  localparam int CTRL_VIDEO = 2;
  localparam int CTRL_YUV = 3;
  localparam int STAT_QOVF = 11;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [6:0] THRESH_RST = 7'h10;
  localparam logic [7:0] STATIC_RST = 8'h00;
  // fetch request stops at this fill level and above, or at the threshold if that is higher
  localparam logic [6:0] Q_HIWAT = 7'h38;
  // palette extension slots
  localparam logic [8:0] PAL_CUR0 = 9'h100;
  localparam logic [8:0] PAL_CUR1 = 9'h101;
  localparam logic [8:0] PAL_LAST = 9'h102;
  // cursor pixel codes
  localparam logic [1:0] CUR_C0 = 2'h0;
  localparam logic [1:0] CUR_C1 = 2'h1;
  localparam logic [1:0] CUR_TRN = 2'h2;
  localparam logic [1:0] CUR_INV = 2'h3;
  // compressed line write-back sequencer
  typedef enum logic [0:0] {WB_IDLE, WB_SEND} drf_wb_e;
endpackage

//--- rtl/drf_queue.sv
// display queue: synchronous first-in first-out store
`timescale 1ns/1ps
module drf_queue import drf_pkg::*; #(
  parameter int WIDTH = Q_WIDTH + 1,
  parameter int DEPTH = Q_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] din_i,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] dout_o,
  // fill state
  output logic [$clog2(DEPTH):0] level_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } drf_q_s;
  drf_q_s s;
  drf_q_s next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr;
  logic rd;

  // pointers wrap for free only with a power-of-two depth
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("queue depth must be a power of two");
    end
  endgenerate

  // flags straight from the count
  assign full_o = s.cnt == DEPTH[AW:0];
  assign empty_o = s.cnt == '0;
  assign level_o = s.cnt;
  assign dout_o = mem[s.rp];
  assign wr = push_i && !full_o;
  assign rd = pop_i && !empty_o;

  // pointer and count update
  always_comb begin
    next_s = s;
    if (wr) begin
      next_s.wp = s.wp + 1'b1;
    end
    if (rd) begin
      next_s.rp = s.rp + 1'b1;
    end
    case ({wr, rd})
      2'b10: next_s.cnt = s.cnt + 1'b1;
      2'b01: next_s.cnt = s.cnt - 1'b1;
      default: next_s.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage has no reset, only the pointers matter
  always_ff @(posedge ref_clk_i) begin
    if (wr) begin
      mem[s.wp] <= din_i;
    end
  end

  queue_full_hold_a: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    (full_o && push_i && !pop_i) |=> full_o && $stable(s.wp))
    else $error("queue accepted a word while full");
endmodule

//--- rtl/drf_display_fetch.sv
// display refresh fetch, line compression and cursor overlay
`timescale 1ns/1ps
// Summary of operation
// - display words queue in a 64 by 64-bit store before output.
// - fill below the software threshold raises a top-priority memory request.
// - cursor pattern words travel through the same display queue.
// - per-line dirty and valid bits; valid clean lines fetch compressed.
// - dirty lines of a live frame fetch from the plain uncompressed frame buffer.
// - programmable static frames ignore dirty bits, use valid bits only.
// - uncompressed lines outside video mode compress into a 64 by 32-bit line buffer.
// - only successfully compressed lines are written back; others dropped.
// - video mode passes YUV 4:2:2 or RGB 5:6:5 words to the port.
// - palette of 256 entries of 18 bits plus three extension entries.
// - 32 by 32 cursor at two bits per pixel overlays the stream.
// - cursor code picks colour 0, colour 1, transparent or inversion.
// - rewriting only the X and Y position moves the cursor.
// - panel or 16 bpp output takes cursor colours from slots 100h, 101h.
module drf_display_fetch import drf_pkg::*; #(
  parameter int LINES = LINES_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // memory controller fetch side
  output logic mem_req_o,
  output logic mem_hipri_o,
  output logic mem_comp_o,
  output logic [LINE_W-1:0] mem_line_o,
  input wire logic mem_rvalid_i,
  input wire logic mem_rcursor_i,
  input wire logic [63:0] mem_rdata_i,
  // compressed line write-back
  output logic mem_cwr_o,
  output logic [31:0] mem_cwdata_o,
  output logic [LINE_W-1:0] mem_cline_o,
  // drawing side dirty marking
  input wire logic dirty_set_i,
  input wire logic [LINE_W-1:0] dirty_line_i,
  // timing generator
  input wire logic frame_start_i,
  input wire logic line_start_i,
  input wire logic [LINE_W-1:0] line_idx_i,
  input wire logic line_end_i,
  input wire logic pix_req_i,
  // pixel output port
  output logic [PAL_W-1:0] out_pix_o,
  output logic out_vld_o,
  output logic out_video_o,
  output logic out_yuv_o
);
  typedef struct packed {
    logic [3:0] ctrl;
    logic [6:0] thr;
    logic [7:0] stat_cnt;
    logic [7:0] stat_left;
    logic live;
    logic [X_W-1:0] cx;
    logic [LINE_W-1:0] cy;
    logic [15:0] cur_idx;
    logic [8:0] pal_adr;
    logic [31:0] rdata;
    logic qovf;
    logic [LINE_W-1:0] line;
    logic comp;
    logic [X_W-1:0] x;
    logic [63:0] w;
    logic have;
    logic [1:0] lane;
    logic [15:0] rep;
    logic [4:0] cur_row;
    logic cact;
    logic chave;
    logic [15:0] cpx;
    logic [15:0] crun;
    logic [6:0] cidx;
    logic covf;
    drf_wb_e wb;
    logic [5:0] wbi;
    logic [5:0] wbn;
    logic [LINE_W-1:0] wbline;
    logic cwr;
    logic [31:0] cwd;
    logic [PAL_W-1:0] opix;
    logic ovld;
  } drf_state_s;

  drf_state_s s;
  drf_state_s next_s;
  logic [PAL_W-1:0] pal [PAL_ENTRIES+PAL_EXT];
  logic [63:0] curm [CUR_SIZE];
  logic [CB_WIDTH-1:0] cbuf [CB_DEPTH];
  logic [LINES-1:0] dirty;
  logic [LINES-1:0] valid;
  logic q_pop;
  logic [Q_WIDTH:0] q_dout;
  logic [6:0] q_lvl;
  logic q_full;
  logic q_empty;
  logic pal_we;
  logic cur_we;
  logic cb_we;
  logic [5:0] cb_adr;
  logic [CB_WIDTH-1:0] cb_dat;
  logic dv_ok;
  logic dv_bad;
  logic go;
  logic ext;
  logic in_cur;
  logic [1:0] code;
  logic [15:0] px;
  logic [31:0] ent;
  logic [PAL_W-1:0] bg;
  logic [PAL_W-1:0] pal_rd;
  logic [X_W-1:0] dx;
  logic [LINE_W-1:0] dy;

  generate
    if (LINES < 1 || LINES > (1 << LINE_W)) begin : g_chk
      $error("line count does not fit the line index");
    end
  endgenerate

  // refresh words and tagged cursor words share one queue
  drf_queue #(
    .WIDTH(Q_WIDTH + 1),
    .DEPTH(Q_DEPTH)
  ) u_queue (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .push_i(mem_rvalid_i),
    .din_i({mem_rcursor_i, mem_rdata_i}),
    .pop_i(q_pop),
    .dout_o(q_dout),
    .level_o(q_lvl),
    .full_o(q_full),
    .empty_o(q_empty)
  );

  // low fill outranks every other pending request
  assign mem_hipri_o = q_lvl < s.thr;
  assign mem_req_o = mem_hipri_o || (q_lvl < Q_HIWAT);
  assign mem_comp_o = s.comp;
  assign mem_line_o = s.line;
  assign mem_cwr_o = s.cwr;
  assign mem_cwdata_o = s.cwd;
  assign mem_cline_o = s.wbline;
  assign reg_rdata_o = s.rdata;
  assign out_pix_o = s.opix;
  assign out_vld_o = s.ovld;
  assign out_video_o = s.ctrl[CTRL_VIDEO];
  assign out_yuv_o = s.ctrl[CTRL_YUV];

  // pixel selection, cursor lookup and palette read
  always_comb begin
    go = pix_req_i && s.have;
    // extension colours for panel or 16 bpp output
    ext = s.ctrl[CTRL_PANEL] || s.ctrl[CTRL_BPP16];
    ent = s.lane[0] ? s.w[63:32] : s.w[31:0];
    px = s.comp ? ent[15:0] : s.w[{s.lane, 4'h0} +: 16];
    // window follows the position registers alone
    dx = s.x - s.cx;
    dy = s.line - s.cy;
    in_cur = (s.x >= s.cx) && (dx < X_W'(CUR_SIZE))
      && (s.line >= s.cy) && (dy < LINE_W'(CUR_SIZE));
    code = curm[dy[4:0]][{dx[4:0], 1'b0} +: 2];
    pal_rd = (s.pal_adr <= PAL_LAST) ? pal[s.pal_adr] : '0;
    if (s.ctrl[CTRL_BPP16]) begin
      bg = {px[15:11], px[15], px[10:5], px[4:0], px[4]};
    end else if (s.ctrl[CTRL_PANEL]) begin
      bg = pal[px[7:0]];
    end else begin
      bg = {10'h000, px[7:0]};
    end
  end

  // main next-state process
  always_comb begin
    next_s = s;
    q_pop = 1'b0;
    pal_we = 1'b0;
    cur_we = 1'b0;
    cb_we = 1'b0;
    cb_adr = s.cidx[5:0];
    cb_dat = {s.crun, s.cpx};
    dv_ok = 1'b0;
    dv_bad = 1'b0;
    next_s.ovld = 1'b0;
    next_s.cwr = 1'b0;
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_CTRL: next_s.ctrl = reg_wdata_i[3:0];
        OFF_THRESH: next_s.thr = reg_wdata_i[6:0];
        OFF_STATIC: next_s.stat_cnt = reg_wdata_i[7:0];
        OFF_CURPOS: begin
          next_s.cx = reg_wdata_i[X_W-1:0];
          next_s.cy = reg_wdata_i[16 +: LINE_W];
        end
        OFF_CURCOL: next_s.cur_idx = reg_wdata_i[15:0];
        OFF_PALADR: next_s.pal_adr = reg_wdata_i[8:0];
        OFF_PALDAT: begin
          pal_we = s.pal_adr <= PAL_LAST;
          next_s.pal_adr = (s.pal_adr >= PAL_LAST) ? 9'h000
            : s.pal_adr + 1'b1;
        end
        OFF_STATUS: next_s.qovf = s.qovf && !reg_wdata_i[STAT_QOVF];
        default: next_s.qovf = s.qovf;
      endcase
    end
    // overflow set wins over a clear in the same cycle
    if (mem_rvalid_i && q_full) begin
      next_s.qovf = 1'b1;
    end
    // register reads, answered one cycle later
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_CTRL: next_s.rdata = {28'h000_0000, s.ctrl};
        OFF_THRESH: next_s.rdata = {25'h000_0000, s.thr};
        OFF_STATIC: next_s.rdata = {24'h00_0000, s.stat_cnt};
        OFF_CURPOS: next_s.rdata = {6'h00, s.cy, 5'h00, s.cx};
        OFF_CURCOL: next_s.rdata = {16'h0000, s.cur_idx};
        OFF_PALADR: next_s.rdata = {23'h00_0000, s.pal_adr};
        OFF_PALDAT: next_s.rdata = {14'h0000, pal_rd};
        OFF_STATUS: next_s.rdata = {20'h0_0000, s.qovf,
          s.wb == WB_SEND, !s.live, s.comp, 1'b0, q_lvl};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // live frame samples dirty bits, then static frames follow
    if (frame_start_i) begin
      next_s.live = s.stat_left == 8'h00;
      next_s.stat_left = (s.stat_left == 8'h00) ? s.stat_cnt
        : s.stat_left - 1'b1;
    end
    // clean valid lines come from the compressed copy
    // dirty lines of a live frame come from the plain frame buffer
    if (line_start_i) begin
      next_s.line = line_idx_i;
      next_s.x = '0;
      next_s.comp = valid[line_idx_i]
        && (!s.live || !dirty[line_idx_i]);
      next_s.cact = !(valid[line_idx_i]
        && (!s.live || !dirty[line_idx_i])) && !s.ctrl[CTRL_VIDEO];
      next_s.chave = 1'b0;
      next_s.cidx = '0;
      next_s.covf = 1'b0;
    end
    // cursor words leave the queue into the pattern store
    if (!q_empty && q_dout[Q_WIDTH]) begin
      q_pop = 1'b1;
      cur_we = 1'b1;
      next_s.cur_row = s.cur_row + 1'b1;
    end else if (!q_empty && !s.have) begin
      q_pop = 1'b1;
      next_s.w = q_dout[Q_WIDTH-1:0];
      next_s.have = 1'b1;
      next_s.lane = 2'h0;
      next_s.rep = '0;
    end
    if (frame_start_i) begin
      next_s.cur_row = '0;
    end
    // one pixel per request while a word is held
    if (go) begin
      next_s.x = s.x + 1'b1;
      next_s.ovld = 1'b1;
      if (s.comp) begin
        // run entries hold length minus one above the pixel
        next_s.rep = s.rep + 1'b1;
        if (s.rep == ent[31:16]) begin
          next_s.rep = '0;
          next_s.lane = s.lane + 1'b1;
          next_s.have = !s.lane[0];
        end
      end else begin
        next_s.lane = s.lane + 1'b1;
        next_s.have = s.lane != 2'h3;
      end
      if (s.ctrl[CTRL_VIDEO]) begin
        next_s.opix = {2'h0, px};
      end else if (!in_cur) begin
        next_s.opix = bg;
      end else begin
        case (code)
          CUR_C0: next_s.opix = ext ? pal[PAL_CUR0]
            : {10'h000, s.cur_idx[7:0]};
          CUR_C1: next_s.opix = ext ? pal[PAL_CUR1]
            : {10'h000, s.cur_idx[15:8]};
          CUR_TRN: next_s.opix = bg;
          CUR_INV: next_s.opix = ext ? ~bg : {10'h000, ~bg[7:0]};
          default: next_s.opix = bg;
        endcase
      end
      // run-length compression into the line buffer
      if (s.cact) begin
        if (s.chave && px == s.cpx && s.crun != 16'hFFFF) begin
          next_s.crun = s.crun + 1'b1;
        end else begin
          if (s.chave) begin
            cb_we = !s.cidx[6];
            next_s.covf = s.covf || s.cidx[6];
            next_s.cidx = s.cidx[6] ? s.cidx : s.cidx + 1'b1;
          end
          next_s.chave = 1'b1;
          next_s.cpx = px;
          next_s.crun = '0;
        end
      end
    end
    // flush last run, keep only a line that fitted
    if (line_end_i && s.cact) begin
      next_s.cact = 1'b0;
      cb_we = s.chave && !s.cidx[6];
      if (s.covf || (s.chave && s.cidx[6]) || !s.chave) begin
        dv_bad = 1'b1;
      end else if (s.wb == WB_IDLE) begin
        next_s.wb = WB_SEND;
        next_s.wbi = '0;
        next_s.wbn = s.cidx[5:0];
        next_s.wbline = s.line;
      end
    end
    // write-back reads stay ahead of the next line's writes
    if (s.wb == WB_SEND) begin
      next_s.cwr = 1'b1;
      next_s.cwd = cbuf[s.wbi];
      next_s.wbi = s.wbi + 1'b1;
      if (s.wbi == s.wbn) begin
        next_s.wb = WB_IDLE;
        dv_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.thr <= THRESH_RST;
      s.stat_cnt <= STATIC_RST;
      s.live <= 1'b1;
      s.wb <= WB_IDLE;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (pal_we) begin
      pal[s.pal_adr] <= reg_wdata_i[PAL_W-1:0];
    end
    if (cur_we) begin
      curm[s.cur_row] <= q_dout[Q_WIDTH-1:0];
    end
    if (cb_we) begin
      cbuf[cb_adr] <= cb_dat;
    end
  end

  // dirty marking from drawing wins over a write-back clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dirty <= '0;
      valid <= '0;
    end else begin
      if (dv_ok) begin
        valid[s.wbline] <= 1'b1;
        dirty[s.wbline] <= 1'b0;
      end
      if (dv_bad) begin
        valid[s.line] <= 1'b0;
      end
      if (dirty_set_i) begin
        dirty[dirty_line_i] <= 1'b1;
      end
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence pix_cursor_s(logic [1:0] c);
    go && in_cur && !s.ctrl[CTRL_VIDEO] && code == c;
  endsequence

  // low fill always raises the priority request
  low_fill_pri_a: assert property (
    (q_lvl < s.thr) |-> (mem_hipri_o && mem_req_o))
    else $error("low queue fill without priority request");
  // static frame picks compressed source on valid alone
  static_src_a: assert property (
    (line_start_i && !s.live && valid[line_idx_i]) |=> mem_comp_o)
    else $error("static frame fetched a valid line uncompressed");
  // dirty line fetched plain in a live frame
  dirty_plain_a: assert property (
    (line_start_i && s.live && dirty[line_idx_i]) |=> !mem_comp_o)
    else $error("dirty line fetched from compressed copy");
  wb_success_a: assert property (
    (line_end_i && s.cact && s.covf) |=> (s.wb == WB_IDLE)
      || $past(s.wb == WB_SEND))
    else $error("failed compression started a write-back");
  cur_transp_a: assert property (
    pix_cursor_s(CUR_TRN) |=> out_pix_o == $past(bg))
    else $error("transparent cursor pixel changed the background");
  // invert code inverts the panel background
  cur_invert_a: assert property (
    (pix_cursor_s(CUR_INV) ##0 ext) |=> out_pix_o == ~$past(bg))
    else $error("inverting cursor pixel wrong");
  // colour 1 from extension slot 101h
  cur_ext_col_a: assert property (
    (pix_cursor_s(CUR_C1) ##0 ext) |=> out_pix_o == $past(pal[PAL_CUR1]))
    else $error("cursor colour 1 not from extension slot");
  // static frames count down once per frame
  static_count_a: assert property (
    (frame_start_i && s.stat_left != 8'h00) |=> !s.live
      && s.stat_left == $past(s.stat_left) - 8'h01)
    else $error("static frame count did not step");
  // a pixel request with a held word answers next cycle
  pix_answer_a: assert property (
    go |=> out_vld_o)
    else $error("pixel request not answered");
endmodule

//--- dv/drf_mem_model.sv
// memory controller model feeding the display queue
`timescale 1ns/1ps
module drf_mem_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // request side and test controls
  input wire logic mem_req_i,
  input wire logic push_all_i,
  input wire logic slow_i,
  // returned words
  output logic mem_rvalid_o,
  output logic mem_rcursor_o,
  output logic [63:0] mem_rdata_o
);
  logic [64:0] q [$];
  logic tog;
  // words queued by the bench, served strictly in order
  task automatic load(input logic c, input logic [63:0] d);
    q.push_back({c, d});
  endtask
  // cursor and refresh words served alike, in load order
  // push_all ignores the request, only to overrun the queue on purpose
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_rvalid_o <= 1'b0;
      mem_rcursor_o <= 1'b0;
      mem_rdata_o <= 64'h0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      if (q.size() > 0 && (mem_req_i || push_all_i) && !(slow_i && tog)) begin
        {mem_rcursor_o, mem_rdata_o} <= q.pop_front();
        mem_rvalid_o <= 1'b1;
      end else begin
        // idle lines churn so a stale word never looks fresh
        mem_rvalid_o <= 1'b0;
        mem_rcursor_o <= ~mem_rcursor_o;
        mem_rdata_o <= ~mem_rdata_o;
      end
    end
  end
endmodule

//--- dv/tb_drf_display_fetch.sv
// self-checking bench for the display refresh fetch block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_drf_display_fetch import drf_pkg::*;;
  localparam logic [3:0] FS = 4'h8, LS = 4'h4, LE = 4'h2, DS = 4'h1;
  localparam logic [63:0] CT = 64'hAAAA_AAAA_AAAA_AAAA;
  localparam logic [63:0] CP = 64'hAAAA_AAAA_AAAA_AAE4;
  localparam logic [63:0] BG = 64'h1357_1357_1357_1357;
  localparam logic [63:0] ALT = 64'h0002_0001_0002_0001;
  logic ref_clk_i, nrst_i, reg_wr_i, reg_rd_i, mem_rvalid_i, mem_rcursor_i;
  logic [15:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, mem_cwdata_o;
  logic [63:0] mem_rdata_i;
  logic mem_req_o, mem_hipri_o, mem_comp_o, mem_cwr_o, out_vld_o;
  logic out_video_o, out_yuv_o, dirty_set_i, frame_start_i, line_start_i;
  logic line_end_i, pix_req_i, push_all, slow;
  logic [LINE_W-1:0] mem_line_o, mem_cline_o, dirty_line_i, line_idx_i;
  logic [LINE_W-1:0] last_cl;
  logic [31:0] last_cw;
  logic [PAL_W-1:0] out_pix_o;
  logic [PAL_W-1:0] px [16];
  logic [15:0] ra [7] = '{OFF_CTRL, OFF_THRESH, OFF_STATIC, OFF_CURPOS,
    OFF_PALADR, OFF_CURCOL, 16'h8400};
  logic [31:0] rv [7] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] pv [4] = '{32'h0001_2345, 32'h0002_0ABC, 32'h0003_0F0F,
    32'h0000_7777};
  int mismatches = 0;
  int compares = 0;
  int cwr_n = 0;

  drf_display_fetch u_drf_display_fetch (
    .ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .mem_req_o, .mem_hipri_o, .mem_comp_o, .mem_line_o,
    .mem_rvalid_i, .mem_rcursor_i, .mem_rdata_i, .mem_cwr_o, .mem_cwdata_o,
    .mem_cline_o, .dirty_set_i, .dirty_line_i, .frame_start_i,
    .line_start_i, .line_idx_i, .line_end_i, .pix_req_i, .out_pix_o,
    .out_vld_o, .out_video_o, .out_yuv_o);
  drf_mem_model u_drf_mem_model (
    .ref_clk_i, .nrst_i, .mem_req_i(mem_req_o), .push_all_i(push_all),
    .slow_i(slow), .mem_rvalid_o(mem_rvalid_i),
    .mem_rcursor_o(mem_rcursor_i), .mem_rdata_o(mem_rdata_i));

  // free-running 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // write-back words seen and the line they belong to
  always @(posedge ref_clk_i) begin
    if (mem_cwr_o === 1'b1) begin
      cwr_n <= cwr_n + 1;
      last_cl <= mem_cline_o;
      last_cw <= mem_cwdata_o;
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    report_and_stop();
  endtask
  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands from the cycle after the strobe until the next read
  task automatic rreg(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  // one-cycle timing pulses: frame, line start, line end, dirty
  task automatic pulse(input logic [3:0] m, input logic [9:0] ln);
    @(posedge ref_clk_i);
    {frame_start_i, line_start_i, line_end_i, dirty_set_i} <= m;
    line_idx_i <= ln;
    dirty_line_i <= ln;
    @(posedge ref_clk_i);
    {frame_start_i, line_start_i, line_end_i, dirty_set_i} <= 4'h0;
  endtask
  // single pixel requests, retried on underrun
  task automatic pix(input int n);
    int i = 0;
    for (int t = 0; i < n; t++) begin
      if (t > 400) hang();
      @(posedge ref_clk_i);
      pix_req_i <= 1'b1;
      @(posedge ref_clk_i);
      pix_req_i <= 1'b0;
      #1;
      if (out_vld_o === 1'b1) begin
        if (i < 16) px[i] = out_pix_o;
        i++;
      end
    end
  endtask
  task automatic src(input logic [9:0] ln, input logic e);
    pulse(LS, ln);
    @(posedge ref_clk_i);
    #1;
    `CHK("line", ln, mem_line_o)
    `CHK("source", e, mem_comp_o)
  endtask

  initial begin
    logic [31:0] d;
    int n0;
    {nrst_i, reg_wr_i, reg_rd_i, pix_req_i, push_all, slow} = '0;
    {dirty_set_i, frame_start_i, line_start_i, line_end_i} = '0;
    {reg_addr_i, reg_wdata_i, dirty_line_i, line_idx_i} = '0;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1;
    `CHK("hipri empty", 1'b1, mem_hipri_o)
    for (int k = 0; k < 7; k++) begin
      rreg(ra[k], d);
      `CHK("reset reg", rv[k], d)
    end
    wreg(OFF_CURCOL, 32'h0000_A55A);
    wreg(16'h8400, 32'hFFFF_FFFF);
    rreg(OFF_CURCOL, d);
    `CHK("colour index", 32'h0000_A55A, d)
    rreg(16'h8400, d);
    `CHK("unmapped", 32'h0, d)
    for (int k = 0; k < 4; k++) begin
      wreg(OFF_CTRL, 32'(k << 2));
      @(posedge ref_clk_i);
      #1;
      `CHK("video", k[0], out_video_o)
      `CHK("yuv", k[1], out_yuv_o)
    end
    // palette slots 100h..102h then wrap to 0
    wreg(OFF_PALADR, 32'h100);
    for (int k = 0; k < 4; k++) wreg(OFF_PALDAT, pv[k]);
    for (int k = 0; k < 4; k++) begin
      wreg(OFF_PALADR, k < 3 ? 32'h100 + k : 32'h0);
      rreg(OFF_PALDAT, d);
      `CHK("palette", pv[k], d)
    end
    $display("test registers done");
    // 16 bpp panel frame: cursor rows then line words, slow memory
    wreg(OFF_CTRL, 32'h3);
    wreg(OFF_CURPOS, 32'h0);
    slow <= 1'b1;
    pulse(FS, 10'h0);
    for (int r = 0; r < 32; r++) u_drf_mem_model.load(1'b1, r < 2 ? CP : CT);
    for (int w = 0; w < 25; w++) u_drf_mem_model.load(1'b0, w < 8 ? BG : ALT);
    repeat (100) @(posedge ref_clk_i);
    #1;
    `CHK("hipri filled", 1'b0, mem_hipri_o)
    wreg(OFF_THRESH, 32'h40);
    #1;
    `CHK("hipri raised", 1'b1, mem_hipri_o)
    `CHK("request", 1'b1, mem_req_o)
    wreg(OFF_THRESH, 32'h10);
    $display("test priority done");
    n0 = cwr_n;
    pulse(LS, 10'h0);
    pix(16);
    pulse(LE, 10'h0);
    repeat (10) @(posedge ref_clk_i);
    `CHK("colour 0", pv[0][17:0], px[0])
    `CHK("colour 1", pv[1][17:0], px[1])
    `CHK("invert", ~px[2], px[3])
    `CHK("transparent", px[2], px[4])
    `CHK("write back", 1, cwr_n - n0)
    `CHK("write back line", 10'h0, last_cl)
    `CHK("write back word", 32'h000F_1357, last_cw)
    wreg(OFF_CURPOS, 32'h4);
    pulse(LS, 10'h1);
    pix(16);
    pulse(LE, 10'h1);
    `CHK("moved c0", pv[0][17:0], px[4])
    `CHK("moved c1", pv[1][17:0], px[5])
    `CHK("moved bg", px[6], px[0])
    repeat (70) @(posedge ref_clk_i);
    n0 = cwr_n;
    pulse(LS, 10'h2);
    pix(68);
    pulse(LE, 10'h2);
    repeat (70) @(posedge ref_clk_i);
    `CHK("no write back", 0, cwr_n - n0)
    $display("test cursor and compression done");
    pulse(FS, 10'h0);
    src(10'h0, 1'b1);
    src(10'h2, 1'b0);
    pulse(DS, 10'h0);
    src(10'h0, 1'b0);
    wreg(OFF_STATIC, 32'h1);
    pulse(FS, 10'h0);
    pulse(FS, 10'h0);
    src(10'h0, 1'b1);
    $display("test line source done");
    // compressed runs through video mode, then 8 bpp cursor indices
    wreg(OFF_CTRL, 32'h4);
    u_drf_mem_model.load(1'b0, 64'h0000_0009_0002_0005);
    pix(4);
    `CHK("run pixel", 18'h0_0005, px[2])
    `CHK("run next", 18'h0_0009, px[3])
    wreg(OFF_CTRL, 32'h0);
    wreg(OFF_CURPOS, 32'h0003_0000);
    pulse(LS, 10'h3);
    u_drf_mem_model.load(1'b0, 64'h0033_0033_0033_0033);
    pix(4);
    `CHK("index c0", 18'h0_005A, px[0])
    `CHK("index c1", 18'h0_00A5, px[1])
    `CHK("index clear", 18'h0_0033, px[2])
    `CHK("index invert", 18'h0_00CC, px[3])
    $display("test video and index done");
    // overrun the 64-entry queue regardless of requests
    slow <= 1'b0;
    push_all <= 1'b1;
    for (int w = 0; w < 70; w++) u_drf_mem_model.load(1'b0, ALT);
    for (int t = 0; u_drf_mem_model.q.size() > 0; t++) begin
      if (t > 200) hang();
      @(posedge ref_clk_i);
    end
    push_all <= 1'b0;
    rreg(OFF_STATUS, d);
    `CHK("overflow", 1'b1, d[STAT_QOVF])
    `CHK("full level", 7'h40, d[6:0])
    wreg(OFF_STATUS, 32'h0000_0800);
    rreg(OFF_STATUS, d);
    `CHK("overflow clear", 1'b0, d[STAT_QOVF])
    $display("test overflow done");
    report_and_stop();
  end
endmodule
